// File: psc_regs.sv
/*
  psc_regs: I2C command-code register bank with fault status, readbacks,
  identity, lock/soft reset, slew field, alert mask and strap decoding.
  Assumes: scl/sda/fault pins/straps are asynchronous and synchronised here;
  measurement inputs come from logic on i_clk; sda is open drain outside.
*/
`default_nettype none
module psc_regs
  import psc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,      // bus address
  parameter logic [7:0] MAKER_CODE = 8'h5c,    // arbitrary value
  parameter logic [15:0] MODEL_CODE = 16'h0b0e, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h03       // arbitrary value
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // i2c pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_alert_n,
  // fault sources
  input wire logic i_overvoltage_flag,
  input wire logic i_undervoltage_flag,
  input wire logic i_overcurrent_flag,
  input wire logic i_overtemp_flag,
  input wire logic i_busy_fault,
  input wire logic i_not_switching,
  input wire logic i_other_fault,
  input wire logic i_power_good_output,
  // measurements
  input wire logic [7:0] i_voltage_code,
  input wire logic [10:0] i_iout_amps,
  // straps
  input wire logic [2:0] i_phase_strap,
  input wire logic [2:0] i_protection_mode_strap,
  input wire logic [2:0] i_soft_start_strap,
  input wire logic [7:0] i_current_limit_strap,
  // decoded controls
  output logic o_straps_valid,
  output logic [5:0] o_phase_enable,
  output logic o_protection_enable,
  output logic o_protection_latch,
  output logic o_overtemp_latch,
  output logic [2:0] o_slew_code,
  output logic [14:0] o_slew_uv_per_us,
  output logic o_lock
);

  // whole module state
  typedef struct packed {
    logic [1:0] scl_sy;      // scl synchroniser
    logic [1:0] sda_sy;      // sda synchroniser
    logic scl_d;             // delayed synced scl
    logic sda_d;             // delayed synced sda
    logic [7:0] flt_sy1;     // fault pin first stage
    logic [7:0] flt_sy2;     // fault pin second stage
    logic [2:0] ph_sy1;
    logic [2:0] ph_sy2;
    logic [2:0] pm_sy1;
    logic [2:0] pm_sy2;
    logic [2:0] ss_sy1;
    logic [2:0] ss_sy2;
    logic [7:0] im_sy1;
    logic [7:0] im_sy2;
    logic [1:0] start_cnt;   // strap settle counter
    logic captured;          // straps taken
    logic [5:0] phase_en;
    logic [2:0] prot;        // enable, latch, temp latch
    logic [2:0] ss_code;     // soft-start strap code
    logic [7:0] current_limit_strap;        // max current, amperes
    psc_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] sh;          // shift register, rx and tx
    logic rw;
    logic [7:0] cmd;
    logic [1:0] bidx;        // byte index within a read or a write
    logic sda_oe;
    logic ack_ok;            // host acked last read byte
    logic [7:0] volt_st;
    logic [7:0] curr_st;
    logic [7:0] comm_st;
    logic [7:0] low_st;      // sticky busy, off, temp, other
    logic lock;
    logic [2:0] slew;
    logic [14:0] slew_uv;
    logic [7:0] mask;
    logic alert;
  } psc_regs_t;

  psc_regs_t r;
  psc_regs_t n;
  logic [15:0] status_word;  // assembled summary word
  logic [15:0] rd_word;      // read value of current command
  logic rd_hit;              // command is readable
  logic clr_fire;            // clear-faults this cycle
  logic srst_fire;           // soft reset this cycle
  logic alert_any;           // unmasked sticky fault other than off present

  // summary word from sticky status and live power good
  assign status_word[7] = r.low_st[PSC_LOW_BUSY_BIT];
  assign status_word[6] = r.low_st[PSC_LOW_OFF_BIT];
  assign status_word[5] = r.volt_st[PSC_VOLT_OV_BIT];
  assign status_word[4] = r.curr_st[PSC_CURR_OC_BIT];
  assign status_word[3] = 1'b0;
  assign status_word[2] = r.low_st[PSC_LOW_TEMP_BIT];
  assign status_word[1] = |r.comm_st;
  assign status_word[0] = r.low_st[PSC_LOW_OTHER_BIT];
  assign status_word[15] = |r.volt_st;
  assign status_word[14] = |r.curr_st;
  assign status_word[13:12] = 2'h0;
  assign status_word[11] = ~r.flt_sy2[PSC_FI_PG];
  assign status_word[10:8] = 3'h0;

  // read decode by command code
  always_comb
  begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    if (r.cmd == PSC_CMD_WORD)
      rd_word = status_word;
    else if (r.cmd == PSC_CMD_VOLT_ST)
      rd_word = {8'h00, r.volt_st};
    else if (r.cmd == PSC_CMD_CURR_ST)
      rd_word = {8'h00, r.curr_st};
    else if (r.cmd == PSC_CMD_COMM_ST)
      rd_word = {8'h00, r.comm_st};
    else if (r.cmd == PSC_CMD_MON_ST)
      rd_word = {8'h00, PSC_MON_ST_VALUE};
    else if (r.cmd == PSC_CMD_VREAD)
      rd_word = {8'h00, i_voltage_code};
    else if (r.cmd == PSC_CMD_IREAD)
      rd_word = {5'h00, i_iout_amps};
    else if (r.cmd == PSC_CMD_MAKER)
      rd_word = {8'h00, MAKER_CODE};
    else if (r.cmd == PSC_CMD_MODEL)
      rd_word = MODEL_CODE;
    else if (r.cmd == PSC_CMD_REV)
      rd_word = {8'h00, REV_CODE};
    else if (r.cmd == PSC_CMD_LOCKRST)
      rd_word = {15'h0000, r.lock};
    else if (r.cmd == PSC_CMD_SLEW)
      rd_word = {8'h00, r.slew, 5'h00};
    else if (r.cmd == PSC_CMD_IMAXRD)
      rd_word = {8'h00, r.current_limit_strap};
    else if (r.cmd == PSC_CMD_MASK)
      rd_word = {8'h00, r.mask};
    else
      rd_hit = 1'b0;
  end

  // next state: i2c slave, writes, status, straps, alert
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic comm_err;
    logic [1:0] idx;
    logic [7:0] tx;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    comm_err = 1'b0;
    idx = 2'h0;
    tx = 8'h00;
    n = r;
    clr_fire = 1'b0;
    srst_fire = 1'b0;
    // synchronisers
    n.scl_sy = {r.scl_sy[0], i_scl};
    n.sda_sy = {r.sda_sy[0], i_sda};
    n.scl_d = r.scl_sy[1];
    n.sda_d = r.sda_sy[1];
    n.flt_sy1 = {i_power_good_output, i_other_fault, i_not_switching, i_busy_fault,
                 i_overtemp_flag, i_overcurrent_flag, i_undervoltage_flag, i_overvoltage_flag};
    n.flt_sy2 = r.flt_sy1;
    n.ph_sy1 = i_phase_strap;
    n.ph_sy2 = r.ph_sy1;
    n.pm_sy1 = i_protection_mode_strap;
    n.pm_sy2 = r.pm_sy1;
    n.ss_sy1 = i_soft_start_strap;
    n.ss_sy2 = r.ss_sy1;
    n.im_sy1 = i_current_limit_strap;
    n.im_sy2 = r.im_sy1;
    scl_rise = r.scl_sy[1] & ~r.scl_d;
    scl_fall = ~r.scl_sy[1] & r.scl_d;
    start_c = r.scl_sy[1] & r.scl_d & r.sda_d & ~r.sda_sy[1];
    stop_c = r.scl_sy[1] & r.scl_d & ~r.sda_d & r.sda_sy[1];
    // bus conditions override any state
    if (start_c)
    begin
      n.st = PSC_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      n.st = PSC_IDLE;
      n.sda_oe = 1'b0;
    end
    else
    begin
      case (r.st)
        // shift in address byte
        PSC_ADDR:
        begin
          if (scl_rise)
          begin
            n.sh = {r.sh[6:0], r.sda_sy[1]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          else if (scl_fall && r.bitcnt == 4'h8)
          begin
            if (r.sh[7:1] == DEV_ADDR)
            begin
              n.rw = r.sh[0];
              n.sda_oe = 1'b1;
              n.st = PSC_ADDR_ACK;
            end
            else
              n.st = PSC_IDLE;
          end
        end
        // release ack, start read or take command
        PSC_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            n.bitcnt = 4'h0;
            if (r.rw)
            begin
              n.bidx = 2'h0;
              tx = rd_word[7:0];
              comm_err = ~rd_hit;
              n.sh = tx;
              n.sda_oe = ~tx[7];
              n.st = PSC_RDATA;
            end
            else
            begin
              n.sda_oe = 1'b0;
              n.st = PSC_CMD;
            end
          end
        end
        // command byte
        PSC_CMD:
        begin
          if (scl_rise)
          begin
            n.sh = {r.sh[6:0], r.sda_sy[1]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          else if (scl_fall && r.bitcnt == 4'h8)
          begin
            n.cmd = r.sh;
            n.bidx = 2'h0;
            n.sda_oe = 1'b1;
            n.st = PSC_CMD_ACK;
            clr_fire = (r.sh == PSC_CMD_CLEAR);
          end
        end
        // ack phases of written bytes
        PSC_CMD_ACK, PSC_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.bitcnt = 4'h0;
            n.st = PSC_WDATA;
          end
        end
        // data byte; only the first one of a write counts
        PSC_WDATA:
        begin
          if (scl_rise)
          begin
            n.sh = {r.sh[6:0], r.sda_sy[1]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          else if (scl_fall && r.bitcnt == 4'h8)
          begin
            n.sda_oe = 1'b1;
            n.st = PSC_WDATA_ACK;
            if (r.bidx == 2'h0)
            begin
              n.bidx = 2'h1;
              if (r.cmd == PSC_CMD_LOCKRST)
              begin
                // whole register ignored once locked
                if (!r.lock)
                begin
                  srst_fire = r.sh[PSC_SRST_BIT];
                  n.lock = r.sh[PSC_LOCK_BIT];
                end
              end
              else if (r.cmd == PSC_CMD_SLEW)
              begin
                if (!r.lock)
                  n.slew = r.sh[7:PSC_SLEW_LSB];
              end
              else if (r.cmd == PSC_CMD_MASK)
              begin
                if (!r.lock)
                  n.mask = r.sh;
              end
              else
                comm_err = 1'b1;
            end
          end
        end
        // drive read bits msb first, changing on scl low
        PSC_RDATA:
        begin
          if (scl_rise)
            n.bitcnt = r.bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (r.bitcnt == 4'h8)
            begin
              n.sda_oe = 1'b0;
              n.st = PSC_RDATA_ACK;
            end
            else
            begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        // host ack decides whether another byte follows
        PSC_RDATA_ACK:
        begin
          if (scl_rise)
            n.ack_ok = ~r.sda_sy[1];
          else if (scl_fall)
          begin
            if (r.ack_ok)
            begin
              idx = (r.bidx == 2'h3) ? r.bidx : r.bidx + 2'h1;
              tx = (idx == 2'h1) ? rd_word[15:8] : 8'h00;
              n.bidx = idx;
              n.sh = tx;
              n.sda_oe = ~tx[7];
              n.bitcnt = 4'h0;
              n.st = PSC_RDATA;
            end
            else
              n.st = PSC_IDLE;
          end
        end
        default:
          n.st = PSC_IDLE;
      endcase
    end
    // strap capture once the synchronisers have settled
    if (r.start_cnt != PSC_STRAP_SETTLE)
      n.start_cnt = r.start_cnt + 2'h1;
    else if (!r.captured)
    begin
      n.captured = 1'b1;
      n.phase_en = psc_phase_decode(r.ph_sy2);
      n.prot = psc_prot_decode(r.pm_sy2);
      n.ss_code = r.ss_sy2;
      n.slew = r.ss_sy2;
      n.current_limit_strap = r.im_sy2;
    end
    // soft reset: power-on values, slew back to soft-start rate
    if (srst_fire)
    begin
      n.mask = PSC_MASK_POR;
      n.slew = r.ss_code;
    end
    // clearing first, so a fault in the same cycle still sets
    if (srst_fire || clr_fire)
    begin
      n.volt_st = 8'h00;
      n.curr_st = 8'h00;
      n.comm_st = 8'h00;
      n.low_st = 8'h00;
    end
    n.volt_st[PSC_VOLT_OV_BIT] = n.volt_st[PSC_VOLT_OV_BIT] | r.flt_sy2[PSC_FI_OV];
    n.volt_st[PSC_VOLT_UV_BIT] = n.volt_st[PSC_VOLT_UV_BIT] | r.flt_sy2[PSC_FI_UV];
    n.curr_st[PSC_CURR_OC_BIT] = n.curr_st[PSC_CURR_OC_BIT] | r.flt_sy2[PSC_FI_OC];
    n.comm_st[PSC_COMM_OTHER_BIT] = n.comm_st[PSC_COMM_OTHER_BIT] | comm_err;
    n.low_st[PSC_LOW_BUSY_BIT] = n.low_st[PSC_LOW_BUSY_BIT] | r.flt_sy2[PSC_FI_BUSY];
    n.low_st[PSC_LOW_OFF_BIT] = n.low_st[PSC_LOW_OFF_BIT] | r.flt_sy2[PSC_FI_OFF];
    n.low_st[PSC_LOW_TEMP_BIT] = n.low_st[PSC_LOW_TEMP_BIT] | r.flt_sy2[PSC_FI_TEMP];
    n.low_st[PSC_LOW_OTHER_BIT] = n.low_st[PSC_LOW_OTHER_BIT] | r.flt_sy2[PSC_FI_OTHER];
    // alert from unmasked sticky faults other than off
    alert_any = (~r.mask[PSC_M_VOLT] & ((r.volt_st[PSC_VOLT_OV_BIT] & ~r.mask[PSC_M_OV]) |
                                        (r.volt_st[PSC_VOLT_UV_BIT] & ~r.mask[PSC_M_UV]))) |
                (~r.mask[PSC_M_CURR] & r.curr_st[PSC_CURR_OC_BIT] & ~r.mask[PSC_M_OC]) |
                (r.low_st[PSC_LOW_TEMP_BIT] & ~r.mask[PSC_M_TEMP]) |
                (~r.mask[PSC_M_COMM] & (|r.comm_st)) |
                r.low_st[PSC_LOW_BUSY_BIT] | r.low_st[PSC_LOW_OTHER_BIT];
    n.alert = alert_any;
    n.slew_uv = PSC_SLEW_UV[n.slew];
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= n;
  end

  // outputs straight from state, except sda data tied low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r.sda_oe;
  assign o_alert_n = ~r.alert;
  assign o_straps_valid = r.captured;
  assign o_phase_enable = r.phase_en;
  assign o_protection_enable = r.prot[2];
  assign o_protection_latch = r.prot[1];
  assign o_overtemp_latch = r.prot[0];
  assign o_slew_code = r.slew;
  assign o_slew_uv_per_us = r.slew_uv;
  assign o_lock = r.lock;

  default clocking psc_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  ov_flag_a: assert property (r.flt_sy2[PSC_FI_OV] |=> r.volt_st[7] && status_word[15] && status_word[5])
    else $error("overvoltage not latched");
  uv_flag_a: assert property (r.flt_sy2[PSC_FI_UV] |=> r.volt_st[4] && status_word[15])
    else $error("undervoltage not latched");
  oc_flag_a: assert property (r.flt_sy2[PSC_FI_OC] |=> r.curr_st[7] && status_word[14] && status_word[4])
    else $error("overcurrent not latched");
  pg_bit_a: assert property ($fell(r.flt_sy2[PSC_FI_PG]) |-> status_word[11] && status_word[13:12] == 2'h0)
    else $error("power good bit wrong");
  lock_keep_a: assert property (r.lock |=> r.lock && $stable(r.mask) && $stable(r.slew))
    else $error("locked state changed");
  soft_reset_a: assert property (srst_fire |=> r.mask == 8'h00 && r.slew == $past(r.ss_code))
    else $error("soft reset did not restore");
  clear_stat_a: assert property ((clr_fire && r.flt_sy2[6:0] == 7'h00) |=> r.volt_st == 8'h00 && r.curr_st == 8'h00)
    else $error("clear faults left status");
  mask_volt_a: assert property ((r.volt_st[7] && !r.mask[7] && !r.mask[5]) |=> !o_alert_n)
    else $error("voltage alert missing");
  mask_all_a: assert property ((r.mask[7:1] == 7'h7f && !r.low_st[7] && !r.low_st[0]) |=> o_alert_n)
    else $error("masked alert raised");
  phase_one_a: assert property (($rose(r.captured) && $past(r.ph_sy2) == 3'h4) |-> o_phase_enable == 6'h01)
    else $error("phase decode wrong");
  slew_load_a: assert property ($rose(r.captured) |-> r.slew == r.ss_code ##1 o_slew_uv_per_us == PSC_SLEW_UV[r.slew])
    else $error("slew not loaded from strap");

endmodule
`default_nettype wire

// File: psc_pkg.sv
/*
  psc_pkg: shared constants for the command-code register bank of a
  multi-phase buck controller: command codes, bit positions, strap codes,
  slew-rate table and strap decoders.
  Assumes: strap inputs arrive already converted to small codes by the
  resistor-sense front end; command codes are I2C command bytes.
*/
`default_nettype none
package psc_pkg;
  // command codes
  localparam logic [7:0] PSC_CMD_CLEAR = 8'h03;
  localparam logic [7:0] PSC_CMD_WORD = 8'h79;
  localparam logic [7:0] PSC_CMD_VOLT_ST = 8'h7a;
  localparam logic [7:0] PSC_CMD_CURR_ST = 8'h7b;
  localparam logic [7:0] PSC_CMD_COMM_ST = 8'h7e;
  localparam logic [7:0] PSC_CMD_MON_ST = 8'h80;
  localparam logic [7:0] PSC_CMD_VREAD = 8'h8b;
  localparam logic [7:0] PSC_CMD_IREAD = 8'h8c;
  localparam logic [7:0] PSC_CMD_MAKER = 8'h99;
  localparam logic [7:0] PSC_CMD_MODEL = 8'h9a;
  localparam logic [7:0] PSC_CMD_REV = 8'h9b;
  localparam logic [7:0] PSC_CMD_LOCKRST = 8'hd0;
  localparam logic [7:0] PSC_CMD_SLEW = 8'hd6;
  localparam logic [7:0] PSC_CMD_IMAXRD = 8'hdd;
  localparam logic [7:0] PSC_CMD_MASK = 8'hf9;
  // power-on values
  localparam logic [7:0] PSC_MASK_POR = 8'h00;
  localparam logic [7:0] PSC_MON_ST_VALUE = 8'h00;
  // fault input vector positions
  localparam int PSC_FI_OV = 0;
  localparam int PSC_FI_UV = 1;
  localparam int PSC_FI_OC = 2;
  localparam int PSC_FI_TEMP = 3;
  localparam int PSC_FI_BUSY = 4;
  localparam int PSC_FI_OFF = 5;
  localparam int PSC_FI_OTHER = 6;
  localparam int PSC_FI_PG = 7;
  // status bit positions
  localparam int PSC_VOLT_OV_BIT = 7;
  localparam int PSC_VOLT_UV_BIT = 4;
  localparam int PSC_CURR_OC_BIT = 7;
  localparam int PSC_COMM_OTHER_BIT = 1;
  localparam int PSC_LOW_BUSY_BIT = 7;
  localparam int PSC_LOW_OFF_BIT = 6;
  localparam int PSC_LOW_TEMP_BIT = 2;
  localparam int PSC_LOW_OTHER_BIT = 0;
  // lock/reset and slew field
  localparam int PSC_LOCK_BIT = 0;
  localparam int PSC_SRST_BIT = 1;
  localparam int PSC_SLEW_LSB = 5;
  // alert mask bits
  localparam int PSC_M_VOLT = 7;
  localparam int PSC_M_CURR = 6;
  localparam int PSC_M_OV = 5;
  localparam int PSC_M_UV = 4;
  localparam int PSC_M_OC = 3;
  localparam int PSC_M_TEMP = 2;
  localparam int PSC_M_COMM = 1;
  // strap settle delay, cycles after reset release
  localparam logic [1:0] PSC_STRAP_SETTLE = 2'h3;
  // slew rate per code, microvolts per microsecond
  localparam logic [14:0] PSC_SLEW_UV [0:7] = '{15'h007d, 15'h00fa, 15'h01f4, 15'h03e8,
                                                 15'h07d0, 15'h0fa0, 15'h1f40, 15'h3e80};
  // phase strap codes
  typedef enum logic [2:0] {
    PSC_PH_FLOAT = 3'h0, PSC_PH_GND = 3'h1, PSC_PH_33K = 3'h2, PSC_PH_13K = 3'h3, PSC_PH_5K1 = 3'h4
  } psc_phase_t;
  // protection strap codes
  typedef enum logic [2:0] {
    PSC_PM_FLOAT = 3'h0, PSC_PM_33K = 3'h1, PSC_PM_20K = 3'h2, PSC_PM_13K = 3'h3,
    PSC_PM_8K2 = 3'h4, PSC_PM_5K1 = 3'h5, PSC_PM_2K7 = 3'h6, PSC_PM_GND = 3'h7
  } psc_prot_t;
  // i2c slave states
  typedef enum logic [3:0] {
    PSC_IDLE = 4'h0, PSC_ADDR = 4'h1, PSC_ADDR_ACK = 4'h2, PSC_CMD = 4'h3, PSC_CMD_ACK = 4'h4,
    PSC_WDATA = 4'h5, PSC_WDATA_ACK = 4'h6, PSC_RDATA = 4'h7, PSC_RDATA_ACK = 4'h8
  } psc_state_t;

  // phase strap to phase enables; unknown codes act as float
  function automatic logic [5:0] psc_phase_decode(input logic [2:0] code);
    logic [5:0] en;
    en = 6'h3f;
    case (code)
      PSC_PH_GND: en = 6'h0f;
      PSC_PH_33K: en = 6'h07;
      PSC_PH_13K: en = 6'h03;
      PSC_PH_5K1: en = 6'h01;
      default: en = 6'h3f;
    endcase
    return en;
  endfunction

  // protection strap to {oc/uv enable, oc/uv latch, temp latch}
  function automatic logic [2:0] psc_prot_decode(input logic [2:0] code);
    logic [2:0] m;
    m = 3'h0;
    case (code)
      PSC_PM_FLOAT: m = 3'h4;
      PSC_PM_33K: m = 3'h5;
      PSC_PM_20K: m = 3'h6;
      PSC_PM_13K: m = 3'h7;
      PSC_PM_8K2: m = 3'h1;
      PSC_PM_5K1: m = 3'h1;
      default: m = 3'h0;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

// File: psc_host.sv
/* psc_host: behavioural i2c host, scl period 48 ns.
   Assumes the bench resolves sda with a pull-up. */
`default_nettype none
module psc_host (
  // resolved data line
  input wire logic i_sda,
  // host pins
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h40;
  // scl stands high between frames
  initial o_scl = 1'b1;
  initial o_sda_low = 1'b0;
  // start or repeated start
  task automatic start();
    #12 o_sda_low = 1'b0;
    #12 o_scl = 1'b1;
    #24 o_sda_low = 1'b1;
    #24 o_scl = 1'b0;
  endtask
  // data moves mid-low, sampled at scl rise
  task automatic bit_io(input logic b, output logic r);
    #12 o_sda_low = ~b;
    #12 o_scl = 1'b1;
    r = i_sda;
    #24 o_scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot
  task automatic byte_io(input logic [7:0] w, input logic k, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(k, a);
  endtask
  task automatic stop();
    #12 o_sda_low = 1'b1;
    #12 o_scl = 1'b1;
    #24 o_sda_low = 1'b0;
    #24;
  endtask
  // command write, data byte only when n is set
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit n);
    logic [7:0] r;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, r);
    byte_io(c, 1'b1, r);
    if (n) byte_io(d, 1'b1, r);
    stop();
  endtask
  // two-byte read, low byte first, nack on the last
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [7:0] r;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, r);
    byte_io(c, 1'b1, r);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hff, 1'b0, v[7:0]);
    byte_io(8'hff, 1'b1, v[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

// File: tb_pmbus_status_control_regs.sv
/* tb_pmbus_status_control_regs: self-checking bench for psc_regs.
   Assumes psc_host as far-side host and a pull-up on sda. */
`default_nettype none
module tb_pmbus_status_control_regs
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] flt = 8'h80; // fault pins, power good high
  logic [7:0] vcode = 8'hb7;
  logic [10:0] amps = 11'h123;
  logic [2:0] ph_s = 3'h2; // phase strap, 33k
  logic [2:0] pm_s = 3'h2; // protection strap, 20k
  logic [2:0] ss_s = 3'h5; // soft-start strap code
  logic [7:0] im_s = 8'h5a; // current limit strap, amperes
  logic sdo;
  logic straps_ok;
  logic scl;
  logic host_low;
  logic oe;
  logic alert_n;
  logic [5:0] ph_en;
  logic [2:0] prot;
  logic [2:0] slew;
  logic [14:0] rate;
  logic lock;
  logic [15:0] v;
  int fail_count = 0;
  int samples_checked = 0;
  wire logic sda = ~host_low & (oe ? sdo : 1'b1); // pulled up unless driven low
  always #2.5 clk = ~clk;
  psc_host host_u (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  // identity values are arbitrary
  psc_regs #(.MAKER_CODE(8'ha7), .MODEL_CODE(16'h2c71), .REV_CODE(8'h06)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(oe),
    .o_alert_n(alert_n), .i_overvoltage_flag(flt[PSC_FI_OV]), .i_undervoltage_flag(flt[PSC_FI_UV]),
    .i_overcurrent_flag(flt[PSC_FI_OC]), .i_overtemp_flag(flt[PSC_FI_TEMP]),
    .i_busy_fault(flt[PSC_FI_BUSY]), .i_not_switching(flt[PSC_FI_OFF]),
    .i_other_fault(flt[PSC_FI_OTHER]), .i_power_good_output(flt[PSC_FI_PG]),
    .i_voltage_code(vcode), .i_iout_amps(amps), .i_phase_strap(ph_s),
    .i_protection_mode_strap(pm_s), .i_soft_start_strap(ss_s), .i_current_limit_strap(im_s),
    .o_straps_valid(straps_ok), .o_phase_enable(ph_en), .o_protection_enable(prot[2]),
    .o_protection_latch(prot[1]), .o_overtemp_latch(prot[0]), .o_slew_code(slew),
    .o_slew_uv_per_us(rate), .o_lock(lock));
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    host_u.rd(c, v);
    chk($sformatf("cmd %h", c), e, v);
  endtask
  // fault pin i active or idle; power good is active low
  task automatic pin(input int i, input logic b);
    @(negedge clk);
    flt[i] = b ^ (i == PSC_FI_PG);
    repeat (8) @(negedge clk);
  endtask
  task automatic clr();
    host_u.wr(PSC_CMD_CLEAR, 8'h00, 1'b0);
  endtask
  // power-on values, identity, readbacks, straps
  task automatic t_por();
    rdc(PSC_CMD_WORD, 16'h0000);
    rdc(PSC_CMD_MAKER, 16'h00a7);
    rdc(PSC_CMD_MODEL, 16'h2c71);
    rdc(PSC_CMD_REV, 16'h0006);
    rdc(PSC_CMD_VREAD, 16'h00b7);
    rdc(PSC_CMD_IREAD, 16'h0123);
    rdc(PSC_CMD_IMAXRD, 16'h005a);
    chk("phases", 16'h0007, 16'(ph_en));
    chk("prot", 16'h0006, 16'(prot));
    chk("slew", 16'h0005, 16'(slew));
    chk("straps_valid", 16'h0001, 16'(straps_ok));
  endtask
  // each fault alone, then clear
  task automatic t_faults();
    logic [15:0] e [8] = '{16'h8020, 16'h8000, 16'h4010, 16'h0004, 16'h0080, 16'h0040, 16'h0001, 16'h0800};
    for (int i = 0; i < 8; i++)
    begin
      pin(i, 1'b1);
      rdc(PSC_CMD_WORD, e[i]);
      pin(i, 1'b0);
      clr();
    end
    rdc(PSC_CMD_WORD, 16'h0000);
    chk("alert_n", 16'h0001, 16'(alert_n));
  endtask
  // persisting faults survive a clear
  task automatic t_persist();
    pin(PSC_FI_OV, 1'b1);
    pin(PSC_FI_UV, 1'b1);
    rdc(PSC_CMD_VOLT_ST, 16'h0090);
    pin(PSC_FI_UV, 1'b0);
    pin(PSC_FI_OC, 1'b1);
    clr();
    rdc(PSC_CMD_CURR_ST, 16'h0080);
    rdc(PSC_CMD_VOLT_ST, 16'h0080);
    chk("alert_n", 16'h0000, 16'(alert_n));
    pin(PSC_FI_OC, 1'b0);
    clr();
  endtask
  // alert masking, overvoltage still held from before
  task automatic t_mask();
    host_u.wr(PSC_CMD_MASK, 8'h20, 1'b1);
    clr();
    chk("alert_n", 16'h0001, 16'(alert_n));
    host_u.wr(PSC_CMD_MASK, 8'h80, 1'b1);
    chk("alert_n", 16'h0001, 16'(alert_n));
    host_u.wr(PSC_CMD_MASK, 8'hfe, 1'b1);
    chk("alert_n", 16'h0001, 16'(alert_n));
    host_u.wr(PSC_CMD_MASK, 8'h00, 1'b1);
    chk("alert_n", 16'h0000, 16'(alert_n));
    pin(PSC_FI_OV, 1'b0);
    clr();
    host_u.wr(PSC_CMD_MASK, 8'h40, 1'b1);
    rdc(PSC_CMD_MASK, 16'h0040);
    rdc(8'h42, 16'h0000);
    rdc(PSC_CMD_WORD, 16'h0002);
    clr();
  endtask
  // slew codes, soft reset, then lock
  task automatic t_slew_lock();
    for (int c = 0; c < 8; c++)
    begin
      host_u.wr(PSC_CMD_SLEW, {c[2:0], 5'h00}, 1'b1);
      chk("rate", 16'(125 << c), 16'(rate));
    end
    host_u.wr(PSC_CMD_LOCKRST, 8'h02, 1'b1);
    rdc(PSC_CMD_MASK, 16'h0000);
    chk("slew", 16'h0005, 16'(slew));
    host_u.wr(PSC_CMD_SLEW, 8'he0, 1'b1);
    host_u.wr(PSC_CMD_LOCKRST, 8'h01, 1'b1);
    chk("lock", 16'h0001, 16'(lock));
    host_u.wr(PSC_CMD_SLEW, 8'h20, 1'b1);
    host_u.wr(PSC_CMD_LOCKRST, 8'h02, 1'b1);
    rdc(PSC_CMD_SLEW, 16'h00e0);
    rdc(PSC_CMD_LOCKRST, 16'h0001);
  endtask
  // second reset mid-run with other straps: lock gone, new decode
  task automatic t_straps();
    @(negedge clk);
    ph_s = 3'h4;
    pm_s = 3'h4;
    ss_s = 3'h1;
    im_s = 8'h30;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("lock", 16'h0000, 16'(lock));
    chk("straps_valid", 16'h0000, 16'(straps_ok));
    repeat (8) @(negedge clk);
    chk("straps_valid", 16'h0001, 16'(straps_ok));
    chk("phases", 16'h0001, 16'(ph_en));
    chk("prot", 16'h0001, 16'(prot));
    chk("rate", 16'h00fa, 16'(rate));
    rdc(PSC_CMD_IMAXRD, 16'h0030);
    rdc(PSC_CMD_SLEW, 16'h0020);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_por();
    t_faults();
    t_persist();
    t_mask();
    t_slew_lock();
    t_straps();
    final_report();
  end
  // hang guard
  initial
  begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
